// file: bench/ppio_pads.sv
`timescale 1ns/100ps
module ppio_pads (
    input  wire logic [16:0] padOut,
    input  wire logic [16:0] padOe,
    input  wire logic [16:0] padPullup,
    input  wire logic [16:0] extDrive,
    input  wire logic [16:0] extVal,
    output logic      [16:0] padIn
);
    // Device wins a fight; a pad nobody holds shows high under its pull-up, else the inverse of padOut, not a stale copy
    assign padIn = (padOe & padOut)
                 | (~padOe & extDrive & extVal)
                 | (~padOe & ~extDrive & (padPullup | ~padOut));
endmodule

// file: bench/ppio_top_asserts.sv
`timescale 1ns/100ps
module ppio_top_asserts #(
    parameter int PINS = 17
) (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [16:0] padOut,
    input wire logic [16:0] padOe,
    input wire logic [16:0] padPullup,
    input wire logic [16:0] padAnalog
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic touched;
    // Pads 15:0 may move only once a write has been answered
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            touched <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            touched <= 1'b1;
        end
    end
    sequence arTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    reset_float_a: assert property (
        !touched |-> padOe[15:0] == 16'h0000 && padPullup[15:0] == 16'hffff)
        else $error("pads left float state before any write");
    analog_quiet_a: assert property ((padAnalog & (padOe | padPullup)) == 17'h00000)
        else $error("analog pin still drives or pulls up");
    low_nopull_a: assert property ((padOe & ~padOut & padPullup) == 17'h00000)
        else $error("pull-up on while pad driven low");
    read_latency_a: assert property (arTake |=> s_axi_rvalid)
        else $error("read answer late");
    write_latency_a: assert property (wrTake |=> s_axi_bvalid)
        else $error("write answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
endmodule
bind ppio_top ppio_top_asserts #(.PINS(PINS)) chk (
    .clock(clock), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .padOut(padOut), .padOe(padOe), .padPullup(padPullup), .padAnalog(padAnalog));

// file: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        clock, sys_rst, awValid, wValid, bReady, arValid, rReady;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [7:0]  awAddr, arAddr;
    logic [31:0] wData, rData;
    logic [1:0]  bResp, rResp;
    logic [3:0]  wStrb;
    logic [16:0] padIn, padOut, padOe, padPullup, padAnalog, extDrive, extVal;
    logic [15:0] periphOut, periphOe, periphIn;
    logic        dbgAct, dbgOut, dbgOe, dbgIn;
    int          fails, samplesChecked;

    ppio_top #(.PINS(17)) dut (
        .clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
        .padAnalog(padAnalog), .periphOut(periphOut), .periphOe(periphOe),
        .periphIn(periphIn), .debugLinkActive(dbgAct), .debugLinkOut(dbgOut),
        .debugLinkOe(dbgOe), .debugLinkIn(dbgIn));
    ppio_pads pads (.padOut(padOut), .padOe(padOe), .padPullup(padPullup),
        .extDrive(extDrive), .extVal(extVal), .padIn(padIn));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic tallyAndFinish;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge clock);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (!bValid);
        bReady <= 1'b0;
        check(32'(bResp), 32'(er));
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge clock);
            if (arReady) arValid <= 1'b0;
        end while (!rValid);
        rReady <= 1'b0;
        check(rData, exp);
        check(32'(rResp), 32'(er));
        @(posedge clock);
    endtask
    // Pad drive is only meaningful where enabled, so compare it masked
    task automatic padChk(input logic [16:0] oe, input logic [16:0] out,
                          input logic [16:0] pu);
        repeat (2) @(posedge clock);
        check(32'(padOe), 32'(oe));
        check(32'(padOut & padOe), 32'(out));
        check(32'(padPullup), 32'(pu));
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        tallyAndFinish();
    end

    initial begin
        sys_rst = 1'b1;
        {awValid, wValid, bReady, arValid, rReady, dbgAct, dbgOut, dbgOe} = 8'h00;
        {awAddr, arAddr, wData} = 48'h0;
        wStrb = 4'hf;
        {extDrive, extVal, periphOut, periphOe} = 66'h0;
        {fails, samplesChecked} = 64'h0;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rd(ppio_pkg::OFF_INPUT_MODE, 32'h1ffff, ppio_pkg::RESP_OKAY);
        rd(ppio_pkg::OFF_OUTPUT_VAL, 32'h1ffff, ppio_pkg::RESP_OKAY);
        // Only byte lane one is strobed, so only bits 15:8 clear
        wStrb <= 4'h2;
        wr(ppio_pkg::OFF_OUTPUT_VAL, 32'h0, ppio_pkg::RESP_OKAY);
        wStrb <= 4'hf;
        rd(ppio_pkg::OFF_OUTPUT_VAL, 32'h100ff, ppio_pkg::RESP_OKAY);
        rd(ppio_pkg::OFF_CONTROL, 32'h0, ppio_pkg::RESP_OKAY);
        wr(8'h1c, 32'hffffffff, ppio_pkg::RESP_SLVERR);
        rd(8'h1c, 32'h0, ppio_pkg::RESP_SLVERR);
        wr(ppio_pkg::OFF_PIN_STATE, 32'h0, ppio_pkg::RESP_OKAY);
        wr(ppio_pkg::OFF_OUTPUT_MODE, 32'h1, ppio_pkg::RESP_OKAY);
        wr(ppio_pkg::OFF_OUTPUT_VAL, 32'h0, ppio_pkg::RESP_OKAY);
        padChk(17'h0, 17'h0, 17'h1ffff);
        wr(ppio_pkg::OFF_CONTROL, 32'h1, ppio_pkg::RESP_OKAY);
        padChk(17'h1ffff, 17'h0, 17'h0);
        wr(ppio_pkg::OFF_OUTPUT_VAL, 32'h1ffff, ppio_pkg::RESP_OKAY);
        padChk(17'h1, 17'h1, 17'h1ffff);
        extDrive <= 17'h20;
        repeat (6) @(posedge clock);
        rd(ppio_pkg::OFF_PIN_STATE, 32'h1ffdf, ppio_pkg::RESP_OKAY);
        // Analog pins chosen for external signals, as software is advised to
        wr(ppio_pkg::OFF_INPUT_MODE, 32'h1ffdd, ppio_pkg::RESP_OKAY);
        extDrive <= 17'h22;
        extVal <= 17'h02;
        padChk(17'h1, 17'h1, 17'h1ffdd);
        check(32'(padAnalog), 32'h22);
        repeat (6) @(posedge clock);
        rd(ppio_pkg::OFF_PIN_STATE, 32'h1ffdd, ppio_pkg::RESP_OKAY);
        wr(ppio_pkg::OFF_CONTROL, 32'h3, ppio_pkg::RESP_OKAY);
        padChk(17'h1, 17'h1, 17'h0);
        wr(ppio_pkg::OFF_CONTROL, 32'h1, ppio_pkg::RESP_OKAY);
        wr(ppio_pkg::OFF_INPUT_MODE, 32'h1ffff, ppio_pkg::RESP_OKAY);
        extDrive <= 17'h0;
        periphOe <= 16'h0101;
        wr(ppio_pkg::OFF_XSEL_FIRST, 32'h1, ppio_pkg::RESP_OKAY);
        wr(ppio_pkg::OFF_XSEL_SECOND, 32'h1, ppio_pkg::RESP_OKAY);
        dbgAct <= 1'b1;
        dbgOe <= 1'b1;
        padChk(17'h10003, 17'h0, 17'h0fffc);
        repeat (6) @(posedge clock);
        check(32'(periphIn), 32'hfefe);
        check(32'(dbgIn), 32'h0);
        rd(ppio_pkg::OFF_PIN_STATE, 32'h0fffc, ppio_pkg::RESP_OKAY);
        // Reset in mid-run must drop every drive and restore the pull-ups
        dbgAct <= 1'b0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        padChk(17'h0, 17'h0, 17'h1ffff);
        rd(ppio_pkg::OFF_CONTROL, 32'h0, ppio_pkg::RESP_OKAY);
        tallyAndFinish();
    end
endmodule

// file: common/ppio_pkg.sv
// Behaviour
// - Software picks analog or digital mode for each pin.
// - After reset pins float with weak pull-ups until crossbar is enabled; an active debug link can drive the last pin before that.
// - Analog pin: pull-up, output driver and input receiver off; last pin still driven by an active debug link and sampled for debugLinkIn.
// - Reading an analog pin always gives 0.
// - Reading a digital pin gives the sampled pad level, not the output value.
// - Push-pull digital pin drives pad high or low per output value.
// - Open-drain pin never drives high; drives low only for value 0.
// - Floating digital pin gets its weak pull-up enabled.
// - Pull-up is off while the pin drives its pad low.
// - Global pull-up disable turns off every pull-up.
// - Pin state reads return pad states whatever the crossbar assignment.
// - Seventeen pins; all but the last serve GPIO, peripheral or analog.
// - Last pin is GPIO only, shared with the debug link data line.
// - Ports zero and one choose push-pull or open-drain per pin.
// - Two crossbar select settings route peripheral functions to pins.
package ppio_pkg;
    localparam int PIN_COUNT     = 17;
    localparam int XBAR_PINS     = 16;
    localparam int FUNC_COUNT    = 16;
    localparam int ADDR_W        = 8;

    localparam logic [7:0] OFF_INPUT_MODE  = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_MODE = 8'h04;
    localparam logic [7:0] OFF_OUTPUT_VAL  = 8'h08;
    localparam logic [7:0] OFF_CONTROL     = 8'h0c;
    localparam logic [7:0] OFF_XSEL_FIRST  = 8'h10;
    localparam logic [7:0] OFF_XSEL_SECOND = 8'h14;
    localparam logic [7:0] OFF_PIN_STATE   = 8'h18;

    localparam int CTRL_XBAR_BIT = 0;
    localparam int CTRL_WPUD_BIT = 1;

    localparam logic [16:0] INPUT_MODE_RST  = 17'h1ffff;
    localparam logic [15:0] OUTPUT_MODE_RST = 16'h0000;
    localparam logic [16:0] OUTPUT_VAL_RST  = 17'h1ffff;
    localparam logic [7:0]  XSEL_RST        = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [16:0] inputMode;
        logic [15:0] outputMode;
        logic [16:0] outputVal;
        logic        crossbarEnable;
        logic        weakPullupGlobalDisable;
        logic [7:0]  selFirst;
        logic [7:0]  selSecond;
        logic        awHave;
        logic [7:0]  awAddr;
        logic        wHave;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [16:0] padOut;
        logic [16:0] padOe;
        logic [16:0] padPullup;
        logic [16:0] padAnalog;
        logic [15:0] periphIn;
    } ppio_state_s;
endpackage

// file: verilog/ppio_sync.sv
`timescale 1ns/100ps
module ppio_sync #(
    parameter int WIDTH = 17
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] stable
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] held;
    } ppio_sync_s;

    ppio_sync_s st;
    ppio_sync_s next_st;

    if (WIDTH < 1) begin : g_bad_width
        $error("ppio_sync: WIDTH must be at least 1");
    end

    always_comb begin
        next_st    = st;
        next_st.s1 = async;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Only a level seen twice in a row counts
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.held[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            // Pads rest high under their pull-ups, so no false low after reset
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign stable = st.held;
endmodule

// file: verilog/ppio_top.sv
`timescale 1ns/100ps
module ppio_top #(
    parameter int PINS = 17
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [16:0] padIn,
    output logic [16:0]      padOut,
    output logic [16:0]      padOe,
    output logic [16:0]      padPullup,
    output logic [16:0]      padAnalog,
    input  wire logic [15:0] periphOut,
    input  wire logic [15:0] periphOe,
    output logic [15:0]      periphIn,
    input  wire logic        debugLinkActive,
    input  wire logic        debugLinkOut,
    input  wire logic        debugLinkOe,
    output logic             debugLinkIn
);
    localparam int LAST = ppio_pkg::PIN_COUNT - 1;

    ppio_pkg::ppio_state_s st;
    ppio_pkg::ppio_state_s next_st;

    logic [16:0] padSync;
    logic [16:0] pinRead;
    logic        awTake;
    logic        wTake;
    logic        arTake;

    // Pin map is fixed: sixteen crossbar pins plus the debug-shared one
    if (PINS != ppio_pkg::PIN_COUNT) begin : g_bad_pins
        $error("ppio_top: PINS must equal 17");
    end

    if (ppio_pkg::XBAR_PINS != ppio_pkg::PIN_COUNT - 1) begin : g_bad_xbar
        $error("ppio_top: crossbar must cover every pin but the last");
    end

    // Two eight-bit select registers carry the function enables
    if (ppio_pkg::FUNC_COUNT != 16) begin : g_bad_func
        $error("ppio_top: FUNC_COUNT must equal 16");
    end

    if (ppio_pkg::ADDR_W != 8) begin : g_bad_addr
        $error("ppio_top: address ports are eight bits wide");
    end

    // Sampled pads feed register reads and crossbar inputs alike
    ppio_sync #(
        .WIDTH (ppio_pkg::PIN_COUNT)
    ) u_pad_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .async   (padIn),
        .stable  (padSync)
    );

    // Analog pins read 0, digital pins read the pad, never the latch
    assign pinRead = padSync & st.inputMode;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic known(input logic [7:0] a);
        logic hit;
        hit = (a[7:2] == ppio_pkg::OFF_INPUT_MODE[7:2])
           || (a[7:2] == ppio_pkg::OFF_OUTPUT_MODE[7:2])
           || (a[7:2] == ppio_pkg::OFF_OUTPUT_VAL[7:2])
           || (a[7:2] == ppio_pkg::OFF_CONTROL[7:2])
           || (a[7:2] == ppio_pkg::OFF_XSEL_FIRST[7:2])
           || (a[7:2] == ppio_pkg::OFF_XSEL_SECOND[7:2])
           || (a[7:2] == ppio_pkg::OFF_PIN_STATE[7:2]);
        return hit;
    endfunction

    // Readies stay low while an answer waits: one write and one read at a time
    assign s_axi_awready = !st.awHave && !st.bValid;
    assign s_axi_wready  = !st.wHave && !st.bValid;
    assign s_axi_arready = !st.rValid;
    assign awTake        = s_axi_awvalid && s_axi_awready;
    assign wTake         = s_axi_wvalid && s_axi_wready;
    assign arTake        = s_axi_arvalid && s_axi_arready;

    always_comb begin
        logic        aHave;
        logic [7:0]  aAddr;
        logic        dHave;
        logic [31:0] dData;
        logic [3:0]  dStrb;
        logic [31:0] cur;
        logic [31:0] upd;
        logic [31:0] rd;
        logic [15:0] funcEn;
        logic [15:0] ownValid;
        logic [3:0]  ownFunc [16];
        logic [15:0] funcHas;
        logic [3:0]  funcPin [16];
        logic [4:0]  slot;
        logic        val;
        logic        pushPull;
        logic        drive;
        aHave    = st.awHave || awTake;
        aAddr    = st.awHave ? st.awAddr : s_axi_awaddr;
        dHave    = st.wHave || wTake;
        dData    = st.wHave ? st.wData : s_axi_wdata;
        dStrb    = st.wHave ? st.wStrb : s_axi_wstrb;
        cur      = '0;
        upd      = '0;
        rd       = '0;
        funcEn   = {st.selSecond, st.selFirst};
        ownValid = '0;
        funcHas  = '0;
        slot     = '0;
        val      = 1'b1;
        pushPull = 1'b0;
        drive    = 1'b0;
        for (int k = 0; k < 16; k++) begin
            ownFunc[k] = '0;
            funcPin[k] = '0;
        end
        next_st = st;

        // Write path: address and data may arrive in either order
        next_st.awHave = aHave;
        next_st.awAddr = aAddr;
        next_st.wHave  = dHave;
        next_st.wData  = dData;
        next_st.wStrb  = dStrb;
        if (st.bValid && s_axi_bready) begin
            next_st.bValid = 1'b0;
        end
        // Strobed bytes merge; bits above a register's width are dropped
        if (aHave && dHave && !st.bValid) begin
            next_st.awHave = 1'b0;
            next_st.wHave  = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp  = known(aAddr) ? ppio_pkg::RESP_OKAY : ppio_pkg::RESP_SLVERR;
            case (aAddr[7:2])
                ppio_pkg::OFF_INPUT_MODE[7:2]: begin
                    upd = merge({15'h0000, st.inputMode}, dData, dStrb);
                    next_st.inputMode = upd[16:0];
                end
                ppio_pkg::OFF_OUTPUT_MODE[7:2]: begin
                    upd = merge({16'h0000, st.outputMode}, dData, dStrb);
                    next_st.outputMode = upd[15:0];
                end
                ppio_pkg::OFF_OUTPUT_VAL[7:2]: begin
                    upd = merge({15'h0000, st.outputVal}, dData, dStrb);
                    next_st.outputVal = upd[16:0];
                end
                ppio_pkg::OFF_CONTROL[7:2]: begin
                    cur = '0;
                    cur[ppio_pkg::CTRL_XBAR_BIT] = st.crossbarEnable;
                    cur[ppio_pkg::CTRL_WPUD_BIT] = st.weakPullupGlobalDisable;
                    upd = merge(cur, dData, dStrb);
                    next_st.crossbarEnable          = upd[ppio_pkg::CTRL_XBAR_BIT];
                    next_st.weakPullupGlobalDisable = upd[ppio_pkg::CTRL_WPUD_BIT];
                end
                ppio_pkg::OFF_XSEL_FIRST[7:2]: begin
                    upd = merge({24'h000000, st.selFirst}, dData, dStrb);
                    next_st.selFirst = upd[7:0];
                end
                ppio_pkg::OFF_XSEL_SECOND[7:2]: begin
                    upd = merge({24'h000000, st.selSecond}, dData, dStrb);
                    next_st.selSecond = upd[7:0];
                end
                default: begin
                    upd = '0;
                end
            endcase
        end

        // Read path
        // Data is captured at acceptance, so it holds while rvalid waits
        if (st.rValid && s_axi_rready) begin
            next_st.rValid = 1'b0;
        end
        if (arTake) begin
            case (s_axi_araddr[7:2])
                ppio_pkg::OFF_INPUT_MODE[7:2]:  rd = {15'h0000, st.inputMode};
                ppio_pkg::OFF_OUTPUT_MODE[7:2]: rd = {16'h0000, st.outputMode};
                ppio_pkg::OFF_OUTPUT_VAL[7:2]:  rd = {15'h0000, st.outputVal};
                ppio_pkg::OFF_CONTROL[7:2]: begin
                    rd[ppio_pkg::CTRL_XBAR_BIT] = st.crossbarEnable;
                    rd[ppio_pkg::CTRL_WPUD_BIT] = st.weakPullupGlobalDisable;
                end
                ppio_pkg::OFF_XSEL_FIRST[7:2]:  rd = {24'h000000, st.selFirst};
                ppio_pkg::OFF_XSEL_SECOND[7:2]: rd = {24'h000000, st.selSecond};
                ppio_pkg::OFF_PIN_STATE[7:2]:   rd = {15'h0000, pinRead};
                default:                        rd = '0;
            endcase
            next_st.rValid = 1'b1;
            next_st.rData  = rd;
            next_st.rResp  = known(s_axi_araddr) ? ppio_pkg::RESP_OKAY : ppio_pkg::RESP_SLVERR;
        end

        // Each enabled function takes the lowest free pin, in function order
        // Limitation: no skipped pins and no fixed pin pairs
        for (int f = 0; f < ppio_pkg::FUNC_COUNT; f++) begin
            if (funcEn[f] && slot < 5'(ppio_pkg::XBAR_PINS)) begin
                ownValid[slot[3:0]] = 1'b1;
                ownFunc[slot[3:0]]  = 4'(f);
                funcHas[f]          = 1'b1;
                funcPin[f]          = slot[3:0];
                slot                = slot + 5'h01;
            end
        end
        // Unassigned functions see an idle high input
        for (int f = 0; f < ppio_pkg::FUNC_COUNT; f++) begin
            next_st.periphIn[f] = funcHas[f] ? pinRead[funcPin[f]] : 1'b1;
        end

        // Pad drive for crossbar-capable pins
        for (int p = 0; p < ppio_pkg::XBAR_PINS; p++) begin
            if (ownValid[p]) begin
                // A peripheral that is not driving counts as a 1: released if open-drain, driven high if push-pull
                val = periphOe[ownFunc[p]] ? periphOut[ownFunc[p]] : 1'b1;
            end else begin
                val = st.outputVal[p];
            end
            // Open-drain never drives high; a 1 hands the pad to its pull-up
            pushPull = st.outputMode[p];
            drive    = st.crossbarEnable && st.inputMode[p];
            next_st.padOut[p] = pushPull ? val : 1'b0;
            next_st.padOe[p]  = drive && (pushPull || !val);
        end

        // Last pin: GPIO only, debug link takes it over while active
        if (debugLinkActive) begin
            // Link owns the pad drive outright; mode and crossbar do not apply to it
            next_st.padOut[LAST] = debugLinkOut;
            next_st.padOe[LAST]  = debugLinkOe;
        end else begin
            // Fixed open-drain: the shared debug line must never be driven high by GPIO
            next_st.padOut[LAST] = 1'b0;
            next_st.padOe[LAST]  = st.crossbarEnable && st.inputMode[LAST]
                                && !st.outputVal[LAST];
        end

        // Pull-up follows the new drive so both change on the same edge
        for (int p = 0; p < ppio_pkg::PIN_COUNT; p++) begin
            next_st.padAnalog[p] = !st.inputMode[p];
            next_st.padPullup[p] = st.inputMode[p]
                                && !st.weakPullupGlobalDisable
                                && !(next_st.padOe[p] && !next_st.padOut[p]);
        end
    end

    // Reset: every pad floats under its pull-up until the crossbar is enabled, except the last one while the debug link drives it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st            <= '0;
            st.inputMode  <= ppio_pkg::INPUT_MODE_RST;
            st.outputMode <= ppio_pkg::OUTPUT_MODE_RST;
            st.outputVal  <= ppio_pkg::OUTPUT_VAL_RST;
            st.selFirst   <= ppio_pkg::XSEL_RST;
            st.selSecond  <= ppio_pkg::XSEL_RST;
            st.padPullup  <= 17'h1ffff;
            st.periphIn   <= 16'hffff;
        end else begin
            st <= next_st;
        end
    end

    // Answers and pad controls all come straight from flops
    assign s_axi_bvalid = st.bValid;
    assign s_axi_bresp  = st.bResp;
    assign s_axi_rvalid = st.rValid;
    assign s_axi_rdata  = st.rData;
    assign s_axi_rresp  = st.rResp;
    assign padOut       = st.padOut;
    assign padOe        = st.padOe;
    assign padPullup    = st.padPullup;
    assign padAnalog    = st.padAnalog;
    assign periphIn     = st.periphIn;
    assign debugLinkIn  = padSync[LAST];
endmodule
